// file: rtl/ebr_pkg.sv
// Purpose: Shared constants and types for the ready-on-read sequencer
// Assumes: Counts are in interface timing-clock cycles
// Notes:   Address and data widths are module parameters
package ebr_pkg;

  localparam int unsigned CNT_W        = 8;
  localparam int unsigned ASYNC_EARLY  = 2;
  localparam logic        MODE_SYNC    = 1'b0;
  localparam logic        MODE_ASYNC   = 1'b1;
  localparam logic        RST_STROBE_N = 1'b1;
  localparam logic        RST_BUS_CLK  = 1'b0;
  localparam logic        RST_TOGGLE   = 1'b0;

  typedef enum logic [2:0]
  {
    EBR_IDLE,
    EBR_ALIGN,
    EBR_LEAD,
    EBR_ACTIVE,
    EBR_WAIT,
    EBR_TRAIL
  } ebr_state_t;

endpackage

// file: rtl/ebr_sync.sv
// Purpose: Two-stage synchroniser for one level
// Assumes: Input is asynchronous to clk_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module ebr_sync
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);

  logic meta;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta  <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule

// file: rtl/ebr_read_seq.sv
// Purpose: Read sequencer for an external parallel bus with ready extension
// Assumes: tim_clk_in is the interface timing clock, unrelated to clk_sys_in
// Notes:   One read in flight; settings are captured with the request
`timescale 1ns/10ps
module ebr_read_seq
#(
  parameter int unsigned ADDR_W = 19,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned FLD_W  = 4
)
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              tim_clk_in,
  input  wire logic              read_req_in,
  input  wire logic [ADDR_W-1:0] read_addr_in,
  input  wire logic [FLD_W-1:0]  read_lead_cycles_in,
  input  wire logic [FLD_W-1:0]  read_active_cycles_in,
  input  wire logic [FLD_W-1:0]  read_trail_cycles_in,
  input  wire logic              ready_enable_setting_in,
  input  wire logic              ready_sampling_select_in,
  input  wire logic              timing_double_select_in,
  input  wire logic              ext_ready_in,
  input  wire logic [DATA_W-1:0] ext_data_bus_in,
  output logic                   busy_out,
  output logic                   read_done_out,
  output logic [DATA_W-1:0]      read_data_out,
  output logic                   zone_select_n_out,
  output logic                   read_strobe_n_out,
  output logic                   write_strobe_n_out,
  output logic                   dir_write_out,
  output logic [ADDR_W-1:0]      ext_address_bus_out,
  output logic                   bus_clock_out
);

  localparam int unsigned CW = ebr_pkg::CNT_W;

  // System-domain request holding registers, stable while busy
  logic [ADDR_W-1:0] addr_q;
  logic [FLD_W-1:0]  lead_q;
  logic [FLD_W-1:0]  act_q;
  logic [FLD_W-1:0]  trail_q;
  logic              use_rdy_q;
  logic              mode_q;
  logic              dbl_q;
  logic              req_tgl;
  logic              done_tgl_s;
  logic              done_tgl_d;

  // Timing-domain state
  ebr_pkg::ebr_state_t state;
  ebr_pkg::ebr_state_t next_state;
  logic [CW-1:0]       pos;
  logic [CW-1:0]       trail_cnt;
  logic                rdy_ok;
  logic                req_s;
  logic                req_d;
  logic                rdy_s;
  logic                done_tgl;
  logic [DATA_W-1:0]   data_tim;
  logic [CW-1:0]       span;

  logic [CW-1:0] eff_lead;
  logic [CW-1:0] eff_act;
  logic [CW-1:0] eff_trail;
  logic [CW-1:0] total;
  logic [CW-1:0] sample_pt;
  logic [CW-1:0] next_pos;
  logic          req_new;
  logic          rdy_hit;
  logic          rdy_now;
  logic          period_done;

  ebr_sync u_req_sync
  (
    .clk_in   (tim_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (req_tgl),
    .q_out    (req_s)
  );

  ebr_sync u_done_sync
  (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .d_in     (done_tgl),
    .q_out    (done_tgl_s)
  );

  ebr_sync u_rdy_sync
  (
    .clk_in   (tim_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (ext_ready_in),
    .q_out    (rdy_s)
  );

  // System side: capture a request, hand it over by toggle
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      addr_q    <= '0;
      lead_q    <= '0;
      act_q     <= '0;
      trail_q   <= '0;
      use_rdy_q <= 1'b0;
      mode_q    <= ebr_pkg::MODE_SYNC;
      dbl_q     <= 1'b0;
      req_tgl   <= ebr_pkg::RST_TOGGLE;
    end
    else if (read_req_in && !busy_out)
    begin
      addr_q    <= read_addr_in;
      lead_q    <= read_lead_cycles_in;
      act_q     <= read_active_cycles_in;
      trail_q   <= read_trail_cycles_in;
      use_rdy_q <= ready_enable_setting_in;
      mode_q    <= ready_sampling_select_in;
      dbl_q     <= timing_double_select_in;
      req_tgl   <= ~req_tgl;
    end
  end

  // Completion: the timing side data is stable once its toggle arrives
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_out      <= 1'b0;
      read_done_out <= 1'b0;
      read_data_out <= '0;
      done_tgl_d    <= ebr_pkg::RST_TOGGLE;
    end
    else
    begin
      done_tgl_d    <= done_tgl_s;
      read_done_out <= done_tgl_s != done_tgl_d;
      if (done_tgl_s != done_tgl_d)
      begin
        busy_out      <= 1'b0;
        read_data_out <= data_tim;
      end
      else if (read_req_in && !busy_out)
      begin
        busy_out <= 1'b1;
      end
    end
  end

  // Effective counts; double timing scales every period by two
  always_comb
  begin
    eff_lead  = dbl_q ? CW'({lead_q, 1'b0})  : CW'(lead_q);
    eff_act   = dbl_q ? CW'({act_q, 1'b0})   : CW'(act_q);
    eff_trail = dbl_q ? CW'({trail_q, 1'b0}) : CW'(trail_q);
    total     = eff_lead + eff_act;
    if (mode_q == ebr_pkg::MODE_ASYNC)
      sample_pt = (total > CW'(ebr_pkg::ASYNC_EARLY)) ?
                  total - CW'(ebr_pkg::ASYNC_EARLY) : '0;
    else
      sample_pt = total;
  end

  assign req_new  = req_s != req_d;
  assign next_pos = pos + CW'(1);
  // Ready pin has no say when the feature is off
  assign rdy_hit  = use_rdy_q ? rdy_s : 1'b1;
  assign rdy_now  = rdy_ok || ((next_pos >= sample_pt) && rdy_hit);
  assign period_done = trail_cnt + CW'(1) >= eff_trail;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ebr_pkg::EBR_IDLE:
        if (req_new)
          // Lead must open on a rising bus clock edge
          next_state = bus_clock_out ? ebr_pkg::EBR_ALIGN
                                     : ebr_pkg::EBR_LEAD;
      ebr_pkg::EBR_ALIGN:
        next_state = ebr_pkg::EBR_LEAD;
      ebr_pkg::EBR_LEAD,
      ebr_pkg::EBR_ACTIVE:
        if (next_pos >= total)
          next_state = rdy_now ? ebr_pkg::EBR_TRAIL
                               : ebr_pkg::EBR_WAIT;
        else if (next_pos >= eff_lead)
          next_state = ebr_pkg::EBR_ACTIVE;
      ebr_pkg::EBR_WAIT:
        if (rdy_hit)
          next_state = ebr_pkg::EBR_TRAIL;
      ebr_pkg::EBR_TRAIL:
        if (period_done)
          next_state = ebr_pkg::EBR_IDLE;
    endcase
  end

  // Bus clock is timing clock over two, so parity of the cycle count picks
  // the bus clock edge that a trail-start strobe change lands on
  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus_clock_out <= ebr_pkg::RST_BUS_CLK;
    else
      bus_clock_out <= ~bus_clock_out;
  end

  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= ebr_pkg::EBR_IDLE;
      req_d <= ebr_pkg::RST_TOGGLE;
    end
    else
    begin
      state <= next_state;
      if (state == ebr_pkg::EBR_IDLE)
        req_d <= req_s;
    end
  end

  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pos       <= '0;
      trail_cnt <= '0;
      rdy_ok    <= 1'b0;
    end
    else
    begin
      if (next_state == ebr_pkg::EBR_LEAD && state != ebr_pkg::EBR_LEAD)
        pos <= '0;
      else if (state == ebr_pkg::EBR_LEAD || state == ebr_pkg::EBR_ACTIVE)
        pos <= next_pos;
      if (state == ebr_pkg::EBR_TRAIL)
        trail_cnt <= trail_cnt + CW'(1);
      else
        trail_cnt <= '0;
      // An early asynchronous hit is kept until the sequencer is back in idle
      if (state == ebr_pkg::EBR_IDLE)
        rdy_ok <= 1'b0;
      else if ((state == ebr_pkg::EBR_LEAD || state == ebr_pkg::EBR_ACTIVE)
               && next_pos >= sample_pt && rdy_hit)
        rdy_ok <= 1'b1;
    end
  end

  // Cycles since the lead opened, waits included; only the parity matters
  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      span <= '0;
    else if (next_state == ebr_pkg::EBR_LEAD && state != ebr_pkg::EBR_LEAD)
      span <= CW'(1);
    else if (next_state == ebr_pkg::EBR_LEAD   ||
             next_state == ebr_pkg::EBR_ACTIVE ||
             next_state == ebr_pkg::EBR_WAIT)
      span <= span + CW'(1);
  end

  // Pins: alignment and idle drive select and strobe inactive; write side is unused
  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      zone_select_n_out   <= ebr_pkg::RST_STROBE_N;
      read_strobe_n_out   <= ebr_pkg::RST_STROBE_N;
      ext_address_bus_out <= '0;
    end
    else
    begin
      zone_select_n_out <= !(next_state == ebr_pkg::EBR_LEAD   ||
                             next_state == ebr_pkg::EBR_ACTIVE ||
                             next_state == ebr_pkg::EBR_WAIT   ||
                             next_state == ebr_pkg::EBR_TRAIL);
      read_strobe_n_out <= !(next_state == ebr_pkg::EBR_ACTIVE ||
                             next_state == ebr_pkg::EBR_WAIT);
      // Address only moves when a lead opens, else it holds
      if (next_state == ebr_pkg::EBR_LEAD && state != ebr_pkg::EBR_LEAD)
        ext_address_bus_out <= addr_q;
    end
  end

  assign write_strobe_n_out = ebr_pkg::RST_STROBE_N;
  assign dir_write_out      = 1'b0;

  // Data taken on the edge that raises the read strobe
  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_tim <= '0;
      done_tgl <= ebr_pkg::RST_TOGGLE;
    end
    else
    begin
      if (!read_strobe_n_out && next_state == ebr_pkg::EBR_TRAIL)
        data_tim <= ext_data_bus_in;
      if (state == ebr_pkg::EBR_TRAIL && period_done)
        done_tgl <= ~done_tgl;
    end
  end

  chk_align_inactive: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    state == ebr_pkg::EBR_ALIGN |->
      zone_select_n_out && read_strobe_n_out)
    else $error("select or strobe active in alignment cycle");

  chk_addr_hold: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    zone_select_n_out && $past(zone_select_n_out) |->
      $stable(ext_address_bus_out))
    else $error("address moved while bus inactive");

  chk_lead_rising: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    $fell(zone_select_n_out) |-> bus_clock_out)
    else $error("lead did not open on rising bus clock");

  chk_wait_strobe: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    $past(state) == ebr_pkg::EBR_WAIT && state == ebr_pkg::EBR_WAIT |->
      !read_strobe_n_out && !zone_select_n_out)
    else $error("read strobe released during wait");

  chk_wait_release: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    state == ebr_pkg::EBR_WAIT && rdy_s |=>
      state == ebr_pkg::EBR_TRAIL ##0 read_strobe_n_out)
    else $error("wait not released one cycle after ready");

  chk_ready_ignored: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    !use_rdy_q |-> state != ebr_pkg::EBR_WAIT)
    else $error("wait entered with ready disabled");

  chk_sync_first: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    state == ebr_pkg::EBR_ACTIVE && mode_q == ebr_pkg::MODE_SYNC &&
    use_rdy_q && next_pos == total && !rdy_s && !rdy_ok |=>
      state == ebr_pkg::EBR_WAIT)
    else $error("low first sample did not extend the read");

  chk_async_early: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    (state == ebr_pkg::EBR_LEAD || state == ebr_pkg::EBR_ACTIVE) &&
    mode_q == ebr_pkg::MODE_ASYNC && use_rdy_q && rdy_s &&
    next_pos == total - CW'(ebr_pkg::ASYNC_EARLY) |=> rdy_ok)
    else $error("early asynchronous sample missed");

  chk_data_capture: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    $rose(read_strobe_n_out) && !zone_select_n_out |->
      data_tim == $past(ext_data_bus_in))
    else $error("read data not taken at strobe release");

  chk_trail_edge: assert property (
    @(posedge tim_clk_in) disable iff (!rst_n_in)
    $rose(read_strobe_n_out) && !zone_select_n_out |->
      bus_clock_out == !span[0])
    else $error("trail strobe change on wrong bus clock edge");

endmodule

// file: test/ebr_mem_model.sv
// Purpose: Memory with a ready line on the far side of the read sequencer
// Assumes: Ready rises a set number of cycles after select falls
// Notes:   Released data bus toggles so stale data never looks valid
`timescale 1ns/10ps
module ebr_mem_model
#(
  parameter int unsigned ADDR_W = 19,
  parameter int unsigned DATA_W = 16
)
(
  input  wire logic              tim_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              zone_select_n_in,
  input  wire logic              read_strobe_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        ready_delay_in,
  output logic                   ext_ready_out,
  output logic [DATA_W-1:0]      data_out
);
  logic [7:0] cnt;

  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt           <= 8'h00;
      ext_ready_out <= 1'b0;
    end
    else if (zone_select_n_in)
    begin
      cnt           <= 8'h00;
      ext_ready_out <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      // Once high, stays high until select rises
      if (cnt >= ready_delay_in)
        ext_ready_out <= 1'b1;
    end
  end

  logic [DATA_W-1:0] idle_q;

  always_ff @(posedge tim_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      idle_q <= '0;
    else
      idle_q <= ~idle_q;
  end

  // Asynchronous part: data follows the strobe, so a one-cycle active works
  assign data_out = !read_strobe_n_in ?
                    addr_in[DATA_W-1:0] ^ DATA_W'(16'h5a5a) : idle_q;
endmodule

// file: test/ebr_read_seq_bench.sv
// Purpose: Self-checking bench for the ready-on-read sequencer
// Assumes: Memory model answers on the timing clock
// Notes:   Strobe and select lengths are measured on the pins
`timescale 1ns/10ps
module ebr_read_seq_bench;
  logic        clk_sys = 0, tim_clk = 0, rst_n = 0, req = 0;
  logic [18:0] addr = '0, ext_addr;
  logic [3:0]  lead = 4'h1, act = 4'h0, trl = 4'h1;
  logic        en = 0, md = 0, dbl = 0, rdy, busy, done;
  logic        zs_n, rs_n, ws_n, dirw, bclk, pz = 1;
  logic [15:0] mdata, rdata;
  logic [7:0]  dly = 8'h00;
  logic [18:0] pa;
  int          err_count = 0, compares = 0, lo = 0, zl = 0, zc = 0;

  always #25 clk_sys = ~clk_sys;
  // Offset keeps timing-clock edges clear of system-clock edges
  initial
  begin
    #0.5;
    forever #3 tim_clk = ~tim_clk;
  end

  ebr_read_seq i_ebr_read_seq (.clk_sys_in(clk_sys), .rst_n_in(rst_n),
    .tim_clk_in(tim_clk), .read_req_in(req), .read_addr_in(addr),
    .read_lead_cycles_in(lead), .read_active_cycles_in(act),
    .read_trail_cycles_in(trl), .ready_enable_setting_in(en),
    .ready_sampling_select_in(md), .timing_double_select_in(dbl),
    .ext_ready_in(rdy), .ext_data_bus_in(mdata), .busy_out(busy),
    .read_done_out(done), .read_data_out(rdata),
    .zone_select_n_out(zs_n), .read_strobe_n_out(rs_n),
    .write_strobe_n_out(ws_n), .dir_write_out(dirw),
    .ext_address_bus_out(ext_addr), .bus_clock_out(bclk));

  ebr_mem_model i_ebr_mem_model (.tim_clk_in(tim_clk), .rst_n_in(rst_n),
    .zone_select_n_in(zs_n), .read_strobe_n_in(rs_n), .addr_in(ext_addr),
    .ready_delay_in(dly), .ext_ready_out(rdy), .data_out(mdata));

  task automatic check_data(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_cnt(string n, int e, int g);
    compares++;
    if (g != e)
    begin
      err_count++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask

  // Pin monitor on the timing clock, values sampled before the edge, lead check 1ns after it
  always @(posedge tim_clk)
  begin
    if (!rs_n)
      lo++;
    if (!zs_n)
      zl++;
    if (zs_n && pz && rst_n)
    begin
      check_data("addr_hold", pa, ext_addr);
      check_data("idle_strobe", 1, rs_n);
    end
    if (zs_n && !pz)
      zc = zl;
    pz = zs_n;
    pa = ext_addr;
    #1;
    if (!zs_n && zl == 0)
      check_data("lead_on_rise", 1, bclk);
  end

  task automatic do_read(logic [18:0] a, logic [3:0] l, ac, t,
                         logic e, m, d, logic [7:0] dl, bit poke);
    int n, k;
    n = 0;
    k = d ? 2 : 1;
    @(posedge clk_sys);
    lo = 0;
    zl = 0;
    zc = 0;
    addr <= a;
    lead <= l;
    act  <= ac;
    trl  <= t;
    en   <= e;
    md   <= m;
    dbl  <= d;
    dly  <= dl;
    req  <= 1;
    @(posedge clk_sys);
    req <= 0;
    if (poke)
    begin
      repeat (2) @(posedge clk_sys);
      addr <= ~a;
      req  <= 1;
      @(posedge clk_sys);
      req <= 0;
    end
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check_data("done", 1, done);
    check_data("rdata", a[15:0] ^ 16'h5a5a, rdata);
    check_data("wr_idle", 2'b10, {ws_n, dirw});
    if (!e || dl == 0)
      check_cnt("strobe_low", ac * k, lo);
    else
      check_cnt("wait_low", 1, int'(lo + l * k >= dl && lo > ac * k));
    check_cnt("zone_low", l * k + lo + t * k, zc);
  endtask

  task automatic print_verdict();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #300us;
    err_count++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    do_read(19'h12345, 4'h2, 4'h3, 4'h1, 0, 0, 0, 8'hff, 0);
    do_read(19'h00abc, 4'h1, 4'h1, 4'h2, 0, 0, 1, 8'hff, 0);
    do_read(19'h7ffff, 4'h2, 4'h3, 4'h1, 1, 0, 0, 8'h00, 0);
    do_read(19'h05555, 4'h3, 4'h3, 4'h1, 1, 1, 0, 8'h00, 0);
    do_read(19'h0aaaa, 4'h2, 4'h3, 4'h2, 1, 0, 0, 8'h0c, 0);
    do_read(19'h03c3c, 4'h2, 4'h3, 4'h1, 1, 1, 0, 8'h0c, 1);
    do_read(19'h01111, 4'h1, 4'h2, 4'h1, 1, 0, 1, 8'h10, 0);
    do_read(19'h02222, 4'h3, 4'h1, 4'h1, 0, 1, 0, 8'hff, 0);
    print_verdict();
  end
endmodule
